// ==== hw/dmc_channel.sv ====
// dma channel event flags, start addresses, progress tracking, apb slave
`timescale 1ns/1ps
`default_nettype none
module dmc_channel (
  input  wire logic               clk,
  input  wire logic               rst_n,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // progress beats from the transfer engine
  input  wire logic               beat_valid,
  input  wire dmc_pkg::dmc_beat_t beat,
  output logic                    beat_ready,
  // requests seen by the interrupt controller
  input  wire dmc_pkg::dmc_irq_req_t irq_req,
  // outputs
  output logic                    irq,
  output logic [31:0]             src_addr,
  output logic [31:0]             dst_addr
);
  import dmc_pkg::*;

  // every flop of the block sits in one state struct, so that reset and
  // update stay in a single place; the next value is built in one
  // combinational process from the present one

  //========================================================================
  // whole module state
  typedef struct packed {
    logic [7:0]       ie;        // event enables
    logic [7:0]       flags;     // event flags
    logic [31:0]      ssa;       // source start address
    logic [31:0]      dsa;       // destination start address
    logic [15:0]      ssiz;      // source size, 0 means 65536
    logic [15:0]      dsiz;      // destination size
    logic [15:0]      csiz;      // cell size
    logic             pat_mode;  // pattern detect mode
    logic             abort_en;  // abort request enable
    logic [7:0]       abort_num; // abort request number
    logic [16:0]      sptr;      // source byte pointer
    logic [16:0]      dptr;      // destination byte pointer
    logic [16:0]      cptr;      // bytes into current cell
    logic [16:0]      bcnt;      // bytes into current block
    dmc_beat_t [1:0]  fifo;      // two-entry beat buffer
    logic             wr_idx;    // buffer write slot
    logic             rd_idx;    // buffer read slot
    logic [1:0]       count;     // entries held
    logic [31:0]      rdata;     // captured read data
    logic             irq;       // registered interrupt request
    logic [31:0]      saddr;     // current source address
    logic [31:0]      daddr;     // current destination address
  } dmc_state_t;

  // s is registered at every edge; next_s is its value for the next edge
  dmc_state_t s;       // present state
  dmc_state_t next_s;  // next state

  //========================================================================
  // helpers
  // a beat may move up to seven bytes, so plain equality would miss a
  // threshold that falls inside one beat; testing the step across it
  // raises the event exactly once
  // true when a counter steps from below a threshold to at or above it
  function automatic logic crossed(input logic [16:0] old_v,
                                   input logic [16:0] new_v,
                                   input logic [16:0] thr);
    crossed = (old_v < thr) && (new_v >= thr);
  endfunction : crossed

  // a 16-bit size field cannot hold 65536, so bit 16 comes from zero
  // zero size stands for the full 65536 bytes
  function automatic logic [16:0] eff_size(input logic [15:0] sz);
    eff_size = {(sz == 16'h0000), sz};
  endfunction : eff_size

  // address decode
  // the full 8-bit offset must match, so aliases stay unmapped
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFS_EVENT, OFS_SSA, OFS_DSA, OFS_SSIZ, OFS_DSIZ,
      OFS_CSIZ, OFS_CTRL, OFS_SPTR, OFS_DPTR: mapped = 1'b1;
      default:                                mapped = 1'b0;
    endcase
  endfunction : mapped

  //========================================================================
  // combinational signals
  // intermediate values, all rebuilt every cycle
  logic             push;       // beat accepted into buffer
  logic             pop;        // beat drained from buffer
  logic             wr_acc;     // apb write in access phase
  logic [7:0]       set_ev;     // events raised this cycle
  dmc_beat_t        hd;         // beat at buffer head
  logic [16:0]      ssz;        // effective source size
  logic [16:0]      dsz;        // effective destination size
  logic [16:0]      csz;        // effective cell size
  logic [16:0]      bsz;        // effective block size
  logic [2:0]       binc;       // bytes counted toward block
  logic [16:0]      sp_new;     // stepped source pointer
  logic [16:0]      dp_new;     // stepped destination pointer
  logic [16:0]      cp_new;     // stepped cell counter
  logic [16:0]      bc_new;     // stepped block counter
  logic [31:0]      rmux;       // read data selected by address

  //========================================================================
  // next-state logic
  // order matters below: beats first, then the abort that overrides the
  // pointers, then software writes, and last the event merge so that a
  // flag raised in the clearing cycle is never lost
  always_comb begin
    next_s  = s;
    set_ev  = 8'h00;
    // buffer handshakes; draining pauses while software accesses the block
    beat_ready = (s.count != 2'd2);
    push    = beat_valid && beat_ready;
    pop     = (s.count != 2'd0) && !psel;
    wr_acc  = psel && penable && pwrite;
    hd      = s.fifo[s.rd_idx];
    ssz     = eff_size(s.ssiz);
    dsz     = eff_size(s.dsiz);
    csz     = eff_size(s.csiz);
    bsz     = (ssz > dsz) ? ssz : dsz;
    binc    = (hd.src_inc > hd.dst_inc) ? hd.src_inc : hd.dst_inc;
    sp_new  = s.sptr + {14'h0000, hd.src_inc};
    dp_new  = s.dptr + {14'h0000, hd.dst_inc};
    cp_new  = s.cptr + {14'h0000, binc};
    bc_new  = s.bcnt + {14'h0000, binc};

    // a full buffer drops beat_ready, so the engine holds its offer
    // fill the buffer
    if (push) begin
      next_s.fifo[s.wr_idx] = beat;
      next_s.wr_idx         = ~s.wr_idx;
    end

    // apply a drained beat to the progress counters
    if (pop) begin
      next_s.rd_idx = ~s.rd_idx;
      next_s.sptr   = sp_new;
      next_s.dptr   = dp_new;
      next_s.cptr   = cp_new;
      next_s.bcnt   = bc_new;
      // thresholds are tested against the pre-beat value, so one beat
      // can raise both the midpoint and the end event
      // source midpoint and end
      if (crossed(s.sptr, sp_new, ssz >> 1)) begin
        set_ev[BIT_SRC_HALF] = 1'b1;
      end
      if (crossed(s.sptr, sp_new, ssz)) begin
        set_ev[BIT_SRC_DONE] = 1'b1;
        next_s.sptr          = RST_PTR;
      end
      // destination midpoint and end
      if (crossed(s.dptr, dp_new, dsz >> 1)) begin
        set_ev[BIT_DST_HALF] = 1'b1;
      end
      if (crossed(s.dptr, dp_new, dsz)) begin
        set_ev[BIT_DST_DONE] = 1'b1;
        next_s.dptr          = RST_PTR;
      end
      // cell boundary
      if (crossed(s.cptr, cp_new, csz)) begin
        set_ev[BIT_CELL_DONE] = 1'b1;
        next_s.cptr           = RST_PTR;
      end
      // the block test comes after the single-pointer tests, so its wrap
      // of all pointers takes precedence over theirs
      // whole block moved: start over
      if (crossed(s.bcnt, bc_new, bsz)) begin
        set_ev[BIT_BLOCK_DONE] = 1'b1;
        next_s.bcnt            = RST_PTR;
        next_s.sptr            = RST_PTR;
        next_s.dptr            = RST_PTR;
        next_s.cptr            = RST_PTR;
      end
      // pattern match ends the block too
      if (hd.pat_hit) begin
        set_ev[BIT_BLOCK_DONE] = 1'b1;
        if (s.pat_mode) begin
          next_s.sptr = RST_PTR;
        end
      end
      // bad source or destination address
      if (hd.addr_err) begin
        set_ev[BIT_ADDR_ERR] = 1'b1;
      end
    end

    // buffer occupancy
    // push and pop in one cycle leave the count unchanged
    case ({push, pop})
      2'b10:   next_s.count = s.count + 2'd1;
      2'b01:   next_s.count = s.count - 2'd1;
      default: next_s.count = s.count;
    endcase

    // abort request from the interrupt controller
    // it clears progress even if a beat drained in the same cycle
    if (irq_req.valid && s.abort_en && (irq_req.num == s.abort_num)) begin
      set_ev[BIT_ABORT] = 1'b1;
      next_s.sptr       = RST_PTR;
      next_s.dptr       = RST_PTR;
      next_s.cptr       = RST_PTR;
      next_s.bcnt       = RST_PTR;
    end

    // writes land at the access edge; unmapped offsets and the pointer
    // offsets are read only here, so neither stores anything
    // software writes
    if (wr_acc) begin
      case (paddr)
        OFS_EVENT: begin
          next_s.ie    = pwdata[IE_LSB +: 8];
          next_s.flags = pwdata[FLAG_LSB +: 8];
        end
        OFS_SSA:  next_s.ssa  = pwdata;
        OFS_DSA:  next_s.dsa  = pwdata;
        OFS_SSIZ: next_s.ssiz = pwdata[15:0];
        OFS_DSIZ: next_s.dsiz = pwdata[15:0];
        OFS_CSIZ: next_s.csiz = pwdata[15:0];
        OFS_CTRL: begin
          next_s.pat_mode  = pwdata[CTRL_PAT_MODE];
          next_s.abort_en  = pwdata[CTRL_ABORT_EN];
          next_s.abort_num = pwdata[CTRL_ABORT_LSB +: 8];
        end
        default: begin
          // unmapped or read-only: nothing stored
        end
      endcase
    end

    // a flag raised in the clearing cycle survives the clear
    next_s.flags = next_s.flags | set_ev;

    // the mux looks at the present state, so a value written in one
    // transfer is seen by a read whose setup follows it
    // read mux, unused bytes read zero
    case (paddr)
      OFS_EVENT: rmux = {8'h00, s.ie, 8'h00, s.flags};
      OFS_SSA:   rmux = s.ssa;
      OFS_DSA:   rmux = s.dsa;
      OFS_SSIZ:  rmux = {16'h0000, s.ssiz};
      OFS_DSIZ:  rmux = {16'h0000, s.dsiz};
      OFS_CSIZ:  rmux = {16'h0000, s.csiz};
      OFS_CTRL:  rmux = {16'h0000, s.abort_num, 6'h00,
                         s.abort_en, s.pat_mode};
      OFS_SPTR:  rmux = {16'h0000, s.sptr[15:0]};
      OFS_DPTR:  rmux = {16'h0000, s.dptr[15:0]};
      default:   rmux = 32'h0000_0000;
    endcase
    // capture read data in the setup cycle
    if (psel && !penable && !pwrite) begin
      next_s.rdata = rmux;
    end

    // these follow the next state, so they change at the same edge as
    // the flag, enable or pointer behind them
    // interrupt request and current buffer addresses
    next_s.irq   = |(next_s.flags & next_s.ie);
    next_s.saddr = next_s.ssa + {15'h0000, next_s.sptr};
    next_s.daddr = next_s.dsa + {15'h0000, next_s.dptr};
  end

  //========================================================================
  // state register, synchronous reset
  // the reset branch loads constants only; '0 covers the buffer, the
  // pointers and the captured read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s           <= '0;
      s.ie        <= RST_IE;
      s.flags     <= RST_FLAGS;
      s.ssa       <= RST_ADDR;
      s.dsa       <= RST_ADDR;
      s.ssiz      <= RST_SIZE;
      s.dsiz      <= RST_SIZE;
      s.csiz      <= RST_SIZE;
      s.abort_num <= RST_ANUM;
    end else begin
      s <= next_s;
    end
  end

  //========================================================================
  // outputs
  // no wait states: every access phase completes at once
  assign prdata   = s.rdata;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign irq      = s.irq;
  assign src_addr = s.saddr;
  assign dst_addr = s.daddr;

endmodule : dmc_channel
`default_nettype wire

// ==== hw/dmc_pkg.sv ====
// package for the dma channel event-flag and start-address block
//==========================================================================
//==========================================================================
`default_nettype none
package dmc_pkg;

  //========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_EVENT  = 8'h00; // flags and enables
  localparam logic [7:0] OFS_SSA    = 8'h10; // source start address
  localparam logic [7:0] OFS_DSA    = 8'h20; // destination start address
  localparam logic [7:0] OFS_SSIZ   = 8'h30; // source size
  localparam logic [7:0] OFS_DSIZ   = 8'h40; // destination size
  localparam logic [7:0] OFS_CSIZ   = 8'h50; // cell size
  localparam logic [7:0] OFS_CTRL   = 8'h60; // pattern mode and abort setup
  localparam logic [7:0] OFS_SPTR   = 8'h70; // source pointer, read only
  localparam logic [7:0] OFS_DPTR   = 8'h80; // destination pointer, read only

  //========================================================================
  // field positions
  localparam int FLAG_LSB        = 0;  // flags in bits 7..0
  localparam int IE_LSB          = 16; // enables in bits 23..16
  localparam int BIT_SRC_DONE    = 7;
  localparam int BIT_SRC_HALF    = 6;
  localparam int BIT_DST_DONE    = 5;
  localparam int BIT_DST_HALF    = 4;
  localparam int BIT_BLOCK_DONE  = 3;
  localparam int BIT_CELL_DONE   = 2;
  localparam int BIT_ABORT       = 1;
  localparam int BIT_ADDR_ERR    = 0;
  localparam int CTRL_PAT_MODE   = 0;  // pattern detect mode
  localparam int CTRL_ABORT_EN   = 1;  // abort request enable
  localparam int CTRL_ABORT_LSB  = 8;  // abort request number 15..8

  //========================================================================
  // reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [7:0]  RST_IE    = 8'h00;
  localparam logic [31:0] RST_ADDR  = 32'h0000_0000;
  localparam logic [15:0] RST_SIZE  = 16'h0000;
  localparam logic [7:0]  RST_ANUM  = 8'hff;
  localparam logic [16:0] RST_PTR   = 17'h0_0000;

  //========================================================================
  // carriers
  typedef struct packed {
    logic [2:0] src_inc;   // source bytes moved by this beat
    logic [2:0] dst_inc;   // destination bytes moved by this beat
    logic       pat_hit;   // pattern detected on this beat
    logic       addr_err;  // source or destination address invalid
  } dmc_beat_t;

  typedef struct packed {
    logic       valid;     // an interrupt request is signalled
    logic [7:0] num;       // its request number
  } dmc_irq_req_t;

endpackage : dmc_pkg
`default_nettype wire

// ==== dv/dmc_channel_monitor.sv ====
// port checker for the dma channel flag and address block
`timescale 1ns/1ps
`default_nettype none
module dmc_channel_monitor
  import dmc_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  beat_valid,
  input wire logic                  beat_ready,
  input wire dmc_pkg::dmc_irq_req_t irq_req,
  input wire logic                  irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //==========================================================================
  // apb phases
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  // a write read back at once returns the written bits under mask
  property p_back(logic [7:0] a, logic [31:0] m);
    s_wr(a) ##1 s_rd(a) |=> (prdata & m) == ($past(pwdata, 2) & m);
  endproperty
  ssa_back_a : assert property (p_back(OFS_SSA, 32'hffffffff))
    else $error("source start readback wrong");
  ie_back_a : assert property (s_wr(OFS_EVENT) ##0 !irq_req.valid
    ##1 s_rd(OFS_EVENT) |=> (prdata & 32'h00ff00ff)
    == ($past(pwdata, 2) & 32'h00ff00ff))
    else $error("event word readback wrong");
  zero_bytes_a : assert property (s_rd(OFS_EVENT) |=>
    prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00)
    else $error("unused event bytes not zero");
  irq_on_a : assert property (s_wr(OFS_EVENT)
    ##0 (|(pwdata[7:0] & pwdata[23:16])) |=> irq)
    else $error("enabled flag gives no irq");
  irq_off_a : assert property (s_wr(OFS_EVENT)
    ##0 (pwdata[7:0] == 8'h00 && !irq_req.valid) |=> !irq)
    else $error("irq stays after flags cleared");
  unmapped_a : assert property (psel && penable
    && (paddr[3:0] != 4'h0 || paddr > OFS_DPTR) |-> pslverr)
    else $error("unmapped access without error");
  drain_a : assert property (!beat_ready && !psel |=> beat_ready)
    else $error("full buffer not drained");
  fill_a : assert property ((psel && beat_valid && beat_ready)[*2]
    |=> !beat_ready)
    else $error("buffer accepts a third beat");
endmodule : dmc_channel_monitor
bind dmc_channel dmc_channel_monitor dmc_channel_monitor_i (.clk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .beat_valid, .beat_ready, .irq_req, .irq);
`default_nettype wire

// ==== dv/dmc_beat_src.sv ====
// transfer engine stand-in that offers progress beats, sometimes slowly
`timescale 1ns/1ps
`default_nettype none
module dmc_beat_src
  import dmc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      beat_ready,
  output var  logic      beat_valid,
  output var  dmc_beat_t beat
);
  dmc_beat_t q[$];  // beats waiting to be offered
  int        seed;  // gap generator
  task push(input dmc_beat_t x);
    q.push_back(x);
  endtask : push
  initial begin
    beat_valid = 1'b0;
    beat = '0;
    seed = 32'h3e34aef9;
  end
  // an offer is held until taken; idle data toggles every cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      beat_valid <= 1'b0;
    end else if (!beat_valid || beat_ready) begin
      if (beat_valid) q.delete(0);
      if (q.size() != 0 && ($random(seed) & 1)) begin
        beat_valid <= 1'b1;
        beat <= q[0];
      end else begin
        beat_valid <= 1'b0;
        beat <= ~beat;
      end
    end
  end
endmodule : dmc_beat_src
`default_nettype wire

// ==== dv/test_dma_channel_irq_and_start_addr.sv ====
// self-checking bench for the dma channel flag and address block
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_irq_and_start_addr;
  import dmc_pkg::*;
  logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic         beat_valid, beat_ready, irq;
  logic [7:0]   paddr, mf, mie, anum;
  logic [1:0]   ctl;
  logic [31:0]  pwdata, prdata, src_addr, dst_addr, rd, ssa, dsa, w;
  dmc_beat_t    beat, b;
  dmc_irq_req_t irq_req;
  int           err_count, check_count, seed, cyc, sp, dp, bc, cc, ss, ds, cs;
  int           vs[3];
  dmc_channel dmc_channel_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .beat_valid, .beat, .beat_ready,
    .irq_req, .irq, .src_addr, .dst_addr);
  dmc_beat_src dmc_beat_src_i (.clk, .rst_n, .beat_ready, .beat_valid, .beat);
  always #5 clk = ~clk;
  // model of one beat taken by the block
  function automatic void apply(dmc_beat_t x);
    int m, ns, nd, nb, nc;
    logic [7:0] f;
    m = x.src_inc > x.dst_inc ? x.src_inc : x.dst_inc;
    ns = sp + x.src_inc;
    nd = dp + x.dst_inc;
    nb = bc + m;
    nc = cc + m;
    f = {7'h00, x.addr_err};
    if (sp < ss / 2 && ns >= ss / 2) f[6] = 1'b1;
    if (sp < ss && ns >= ss) {f[7], ns} = {1'b1, 32'h0};
    if (dp < ds / 2 && nd >= ds / 2) f[4] = 1'b1;
    if (dp < ds && nd >= ds) {f[5], nd} = {1'b1, 32'h0};
    if (cc < cs && nc >= cs) {f[2], nc} = {1'b1, 32'h0};
    m = ss > ds ? ss : ds;
    if (bc < m && nb >= m) {f[3], ns, nd, nb, nc} = {1'b1, 128'h0};
    if (x.pat_hit) f[3] = 1'b1;
    if (x.pat_hit && ctl[0]) ns = 0;
    {sp, dp, bc, cc} = {ns, nd, nb, nc};
    mf = mf | f;
  endfunction : apply
  always @(posedge clk) if (rst_n && beat_valid && beat_ready) apply(beat);
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // apb transfer; returns at the edge that took the answer, request held
  task xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    {pwrite, paddr, pwdata} <= {wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    {er, rd} = {pslverr, prdata};
  endtask : xf
  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : idle
  // drain, compare all results, then rewrite flags and enables
  task verify;
    int n;
    n = 0;
    while ((dmc_beat_src_i.q.size() != 0 || beat_valid) && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    xf(1'b0, OFS_EVENT, 32'h0);
    chk(rd, {8'h00, mie, 8'h00, mf});
    xf(1'b0, OFS_SPTR, 32'h0);
    chk(rd, 32'(sp));
    idle;
    chk(32'(irq), 32'(|(mf & mie)));
    chk(src_addr, ssa + 32'(sp));
    chk(dst_addr, dsa + 32'(dp));
    w = $random(seed);
    if (!w[8]) w[7:0] = 8'h00;
    xf(1'b1, OFS_EVENT, w);
    {mf, mie} = {w[7:0], w[23:16]};
    xf(1'b0, OFS_EVENT, 32'h0);
    chk(rd, {8'h00, mie, 8'h00, mf});
    idle;
  endtask : verify
  task abort_try(input logic [7:0] n);
    irq_req <= '{valid: 1'b1, num: n};
    @(posedge clk);
    irq_req.valid <= 1'b0;
    @(posedge clk);
    if (n == anum && ctl[1]) {mf[1], sp, dp, bc, cc} = {1'b1, 128'h0};
  endtask : abort_try
  task report_and_stop;
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata, irq_req} = '0;
    {err_count, check_count, cyc, sp, dp, bc, cc, mf, mie} = '0;
    seed = 32'h3e34aef9;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xf(1'b0, OFS_EVENT, 32'h0);
    chk(rd, 32'h0);
    xf(1'b0, OFS_DSA, 32'h0);
    chk(rd, 32'h0);
    {ssa, dsa, anum} = {$random(seed), $random(seed), 8'($random(seed))};
    xf(1'b1, OFS_SSA, ssa);
    xf(1'b0, OFS_SSA, 32'h0);
    chk(rd, ssa);
    xf(1'b1, OFS_DSA, dsa);
    xf(1'b0, OFS_DSA, 32'h0);
    chk(rd, dsa);
    xf(1'b0, 8'h04, 32'h0);
    chk({31'h0, er}, 32'h1);
    ctl = 2'b11;
    xf(1'b1, OFS_CTRL, {16'h0, anum, 6'h00, ctl});
    idle;
    for (int r = 0; r < 6; r++) begin
      abort_try(anum ^ 8'h01);
      abort_try(anum);
      verify;
      for (int j = 0; j < 3; j++) begin
        vs[j] = r == 0 && j < 2 ? 0 : 1 + ($random(seed) & 31);
        xf(1'b1, 8'(OFS_SSIZ + 8'h10 * j), 32'(vs[j]));
      end
      idle;
      ss = vs[0] == 0 ? 65536 : vs[0];
      ds = vs[1] == 0 ? 65536 : vs[1];
      cs = vs[2];
      repeat (6) begin
        repeat (1 + ($random(seed) & 3)) begin
          b = 8'($random(seed));
          b.pat_hit = 1'b0;
          dmc_beat_src_i.push(b);
        end
        xf(1'b0, OFS_EVENT, 32'h0);
        xf(1'b0, OFS_SSA, 32'h0);
        idle;
        verify;
      end
    end
    b = 8'h00;
    b.pat_hit = 1'b1;
    dmc_beat_src_i.push(b);
    verify;
    // pattern mode and abort enable off: no pointer reset, no abort flag
    ctl = 2'b00;
    xf(1'b1, OFS_CTRL, {16'h0, anum, 6'h00, ctl});
    xf(1'b1, OFS_EVENT, {8'h00, mie, 16'h0000});
    mf = 8'h00;
    idle;
    abort_try(anum);
    b = 8'h00;
    b.src_inc = 3'd3;
    b.pat_hit = 1'b1;
    dmc_beat_src_i.push(b);
    verify;
    report_and_stop;
  end
endmodule : test_dma_channel_irq_and_start_addr
`default_nettype wire
